// *** hw/dpll_ref_switchover_config.sv ***
// reference selection and switchover configuration for two loops
// assumes a byte register port on sys_clk and asynchronous select pins
// Operation
// - loop2 manual choice: field or pins by bit
// - soft select codes 0-4 pick reference 0-4
// - loop2 mode: nonrevertive, revertive, fallback, holdover
// - always switchover without fast lock: hitless
// - fast lock without always switchover: fast lock
// - neither: hitless unless holdover reached timer
// - fast lock bit forces fast lock always
// - no history: free run or hold last
// - loop1 topology field decodes four topologies
// - timer exponent is five low bits
// - mantissa eleven bits split over two registers
// - input dividers sixteen bits, high byte first
// - phase detector source: off, oscillator, feedback
// - validation bit zero enables loop2 oscillator loopback
`timescale 1ns/1ps
`include "loopcfg_defs.svh"
module dpll_ref_switchover_config
	import loopcfg_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic [`ADDR_W-1:0]  addr,
	input  wire logic [7:0]          wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [7:0]          rd_data,
	input  wire logic [1:0]          loop2_select_pins,
	input  wire logic                loop1_in_holdover,
	input  wire logic                loop1_history_valid,
	output logic      [2:0]          loop2_ref_choice,
	output logic                     loop2_ref_choice_valid,
	output switch_mode_e             loop2_switchover_mode,
	output logic                     loop2_auto_select,
	output logic                     loop2_revertive,
	output topology_e                loop1_topology,
	output logic      [4:0]          loop1_switch_timer_exponent,
	output logic      [10:0]         loop1_switch_timer_mantissa,
	output logic      [15:0]         loop1_in0_divider,
	output logic      [15:0]         loop1_in1_divider,
	output logic      [15:0]         loop1_in2_divider,
	output logic      [15:0]         loop1_in3_divider,
	output logic      [15:0]         loop1_in5_divider,
	output pd_source_e               loop1_phase_detector_source,
	output logic                     loop1_phase_detector_enable,
	output logic                     loop2_oscillator_loopback_enable,
	output logic                     loop1_use_fast_lock,
	output logic                     loop1_use_hitless,
	output logic                     loop1_free_run_active,
	output logic                     loop1_hold_last_active
);
	cfg_state_s      cur;
	cfg_state_s      next_cur;
	logic [7:0]      acc_mask;
	logic [4:0]      acc_idx;
	holdover_state_e ho_state;
	logic [7:0]      r_valid;
	logic [7:0]      r_sel;
	logic [7:0]      r_policy;
	logic [7:0]      r_pd;

	// writable bits of each mapped register, zero when unmapped
	function automatic logic [7:0] reg_mask(input logic [`ADDR_W-1:0] a);
		logic [7:0] m;
		m = 8'h00;
		case (a)
			`OFF_LOOP2_VALIDATION: m = 8'h01;
			`OFF_LOOP2_REF_SEL:    m = 8'h3F;
			`OFF_LOOP1_POLICY:     m = 8'hFF;
			`OFF_TMR_EXP:          m = 8'h1F;
			`OFF_TMR_MANT_HI:      m = 8'h07;
			`OFF_TMR_MANT_LO:      m = 8'hFF;
			`OFF_IN0_DIV_HI:       m = 8'hFF;
			`OFF_IN0_DIV_LO:       m = 8'hFF;
			`OFF_IN1_DIV_HI:       m = 8'hFF;
			`OFF_IN1_DIV_LO:       m = 8'hFF;
			`OFF_IN2_DIV_HI:       m = 8'hFF;
			`OFF_IN2_DIV_LO:       m = 8'hFF;
			`OFF_IN3_DIV_HI:       m = 8'hFF;
			`OFF_IN3_DIV_LO:       m = 8'hFF;
			`OFF_SPARE_A:          m = 8'hFF;
			`OFF_SPARE_B:          m = 8'hFF;
			`OFF_IN5_DIV_HI:       m = 8'hFF;
			`OFF_IN5_DIV_LO:       m = 8'hFF;
			`OFF_PD_SOURCE:        m = 8'h1F;
			`OFF_SPARE_C:          m = 8'h9F;
			`OFF_SPARE_D:          m = 8'h01;
			default:               m = 8'h00;
		endcase
		return m;
	endfunction : reg_mask

	// image slot of a register offset
	function automatic logic [4:0] reg_idx(input logic [`ADDR_W-1:0] a);
		logic [`ADDR_W-1:0] d;
		d = a - `BASE_ADDR;
		return d[4:0];
	endfunction : reg_idx

	// sixteen bit value from a high and a low slot
	function automatic logic [15:0] pair16(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction : pair16

	always_comb begin
		acc_mask = reg_mask(addr);
		acc_idx  = reg_idx(addr);
		next_cur = cur;
		// select pins pass two flops before use
		next_cur.pin_meta = loop2_select_pins;
		next_cur.pin_sync = cur.pin_meta;
		next_cur.rdata    = 8'h00;
		if (wr_en && acc_mask != 8'h00) begin
			// only writable bits change, split fields update byte by byte
			next_cur.image[acc_idx] = (cur.image[acc_idx] & ~acc_mask) | (wr_data & acc_mask);
		end
		if (rd_en && acc_mask != 8'h00) begin
			next_cur.rdata = cur.image[acc_idx] & acc_mask;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '{image: {`NUM_REGS{`REG_RESET}}, pin_meta: 2'b00, pin_sync: 2'b00,
				rdata: 8'h00};
		end else begin
			cur <= next_cur;
		end
	end

	assign rd_data  = cur.rdata;
	assign r_valid  = cur.image[reg_idx(`OFF_LOOP2_VALIDATION)];
	assign r_sel    = cur.image[reg_idx(`OFF_LOOP2_REF_SEL)];
	assign r_policy = cur.image[reg_idx(`OFF_LOOP1_POLICY)];
	assign r_pd     = cur.image[reg_idx(`OFF_PD_SOURCE)];

	// manual reference choice for loop2
	always_comb begin
		if (r_sel[`MAN_SRC_BIT]) begin
			loop2_ref_choice       = {1'b0, cur.pin_sync};
			loop2_ref_choice_valid = 1'b1;
		end else begin
			loop2_ref_choice       = r_sel[`SOFT_REF_HI:`SOFT_REF_LO];
			loop2_ref_choice_valid = r_sel[`SOFT_REF_HI:`SOFT_REF_LO] <= `MAX_SOFT_REF;
		end
	end

	assign loop2_switchover_mode = switch_mode_e'(r_sel[`MODE_HI:`MODE_LO]);
	assign loop2_auto_select     = !r_sel[`MODE_HI];
	assign loop2_revertive       = loop2_switchover_mode == SW_AUTO_REV;

	assign loop1_topology = topology_e'(r_policy[`TOPO_HI:`TOPO_LO]);

	assign loop1_switch_timer_exponent = cur.image[reg_idx(`OFF_TMR_EXP)][`EXP_HI:0];
	assign loop1_switch_timer_mantissa = {cur.image[reg_idx(`OFF_TMR_MANT_HI)][`MANT_HI_BITS:0],
		cur.image[reg_idx(`OFF_TMR_MANT_LO)]};

	assign loop1_in0_divider = pair16(cur.image[reg_idx(`OFF_IN0_DIV_HI)],
		cur.image[reg_idx(`OFF_IN0_DIV_LO)]);
	assign loop1_in1_divider = pair16(cur.image[reg_idx(`OFF_IN1_DIV_HI)],
		cur.image[reg_idx(`OFF_IN1_DIV_LO)]);
	assign loop1_in2_divider = pair16(cur.image[reg_idx(`OFF_IN2_DIV_HI)],
		cur.image[reg_idx(`OFF_IN2_DIV_LO)]);
	assign loop1_in3_divider = pair16(cur.image[reg_idx(`OFF_IN3_DIV_HI)],
		cur.image[reg_idx(`OFF_IN3_DIV_LO)]);
	assign loop1_in5_divider = pair16(cur.image[reg_idx(`OFF_IN5_DIV_HI)],
		cur.image[reg_idx(`OFF_IN5_DIV_LO)]);

	// unlisted code two is treated as disabled
	assign loop1_phase_detector_source = pd_source_e'(r_pd[`PD_HI:`PD_LO]);
	assign loop1_phase_detector_enable = loop1_phase_detector_source == PD_OSC ||
		loop1_phase_detector_source == PD_FEEDBACK;

	assign loop2_oscillator_loopback_enable = r_valid[`LOOPBACK_BIT];

	switch_policy policy (
		.sys_clk           (sys_clk),
		.rst               (rst),
		.always_switchover (r_policy[`ALWAYS_SW_BIT]),
		.always_fast_lock  (r_policy[`ALWAYS_FAST_BIT]),
		.holdover_mode     (r_policy[`HOLDOVER_MODE_BIT]),
		.timer_exponent    (loop1_switch_timer_exponent),
		.timer_mantissa    (loop1_switch_timer_mantissa),
		.in_holdover       (loop1_in_holdover),
		.history_valid     (loop1_history_valid),
		.use_fast_lock     (loop1_use_fast_lock),
		.use_hitless       (loop1_use_hitless),
		.holdover_state    (ho_state)
	);

	assign loop1_free_run_active  = ho_state == HO_FREE_RUN;
	assign loop1_hold_last_active = ho_state == HO_HOLD_LAST;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_readback_value:
	assert property ((wr_en ##1 (rd_en && addr == $past(addr))) |=>
		rd_data == ($past(wr_data, 2) & reg_mask($past(addr, 2))))
	else $error("read back differs from written value");

	a_unmapped_zero:
	assert property ((rd_en && reg_mask(addr) == 8'h00) |=> rd_data == 8'h00)
	else $error("unmapped read not zero");

	a_rdata_one_cycle:
	assert property (!rd_en |=> rd_data == 8'h00)
	else $error("read data outside its cycle");

	a_soft_select:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && !wr_data[`MAN_SRC_BIT]) |=>
		loop2_ref_choice == $past(wr_data[`SOFT_REF_HI:`SOFT_REF_LO]))
	else $error("software choice not applied");

	a_pin_select:
	assert property (($stable(loop2_select_pins) [*3] ##0 r_sel[`MAN_SRC_BIT]) |->
		loop2_ref_choice == {1'b0, loop2_select_pins})
	else $error("pin choice not applied");

	a_soft_valid:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[5:2] == 4'h5) |=>
		!loop2_ref_choice_valid)
	else $error("reserved code shown valid");

	a_mode_write:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[1:0] == 2'h1) |=>
		loop2_revertive && loop2_auto_select)
	else $error("revertive mode not decoded");

	a_hitless_forced:
	assert property ((r_policy[`ALWAYS_SW_BIT] && !r_policy[`ALWAYS_FAST_BIT]) [*2] |->
		loop1_use_hitless && !loop1_use_fast_lock)
	else $error("hitless switchover not chosen");

	a_fast_forced:
	assert property (r_policy[`ALWAYS_FAST_BIT] [*2] |-> loop1_use_fast_lock)
	else $error("fast lock not forced");

	a_fast_write:
	assert property ((wr_en && addr == `OFF_LOOP1_POLICY && wr_data[5:4] == 2'b01) |=>
		##1 loop1_use_fast_lock)
	else $error("fast lock policy not taken");

	a_timer_policy:
	assert property ((r_policy[5:4] == 2'b00 && loop1_switch_timer_mantissa != 11'h000 &&
		!loop1_in_holdover) [*3] |-> loop1_use_hitless)
	else $error("hitless expected before timer");

	a_free_run_entry:
	assert property (($rose(loop1_in_holdover) && !loop1_history_valid &&
		!r_policy[`HOLDOVER_MODE_BIT] && $past(ho_state) == HO_LOCKED) |=>
		loop1_free_run_active && !loop1_hold_last_active)
	else $error("free run not entered");

	a_hold_last_entry:
	assert property (($rose(loop1_in_holdover) && !loop1_history_valid &&
		r_policy[`HOLDOVER_MODE_BIT] && $past(ho_state) == HO_LOCKED) |=>
		loop1_hold_last_active)
	else $error("hold last not entered");

	a_topology_write:
	assert property ((wr_en && addr == `OFF_LOOP1_POLICY) |=>
		loop1_topology == topology_e'($past(wr_data[1:0])))
	else $error("topology not updated");

	a_exponent_write:
	assert property ((wr_en && addr == `OFF_TMR_EXP) |=>
		loop1_switch_timer_exponent == $past(wr_data[4:0]))
	else $error("exponent not updated");

	a_mantissa_high:
	assert property ((wr_en && addr == `OFF_TMR_MANT_HI) |=>
		loop1_switch_timer_mantissa[10:8] == $past(wr_data[2:0]))
	else $error("mantissa high bits not updated");

	a_divider_pair:
	assert property ((wr_en && addr == `OFF_IN5_DIV_HI) ##1
		(wr_en && addr == `OFF_IN5_DIV_LO) |=>
		loop1_in5_divider == {$past(wr_data, 2), $past(wr_data)})
	else $error("divider pair not assembled");

	a_pd_source:
	assert property ((wr_en && addr == `OFF_PD_SOURCE && wr_data[3:2] == 2'h3) |=>
		loop1_phase_detector_source == PD_FEEDBACK && loop1_phase_detector_enable)
	else $error("feedback source not selected");

	a_loopback_write:
	assert property ((wr_en && addr == `OFF_LOOP2_VALIDATION) |=>
		loop2_oscillator_loopback_enable == $past(wr_data[0]))
	else $error("loopback enable not updated");

	a_pin_valid:
	assert property (r_sel[`MAN_SRC_BIT] |-> loop2_ref_choice_valid)
	else $error("pin choice shown invalid");

	a_soft_ref_four:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[5:2] == 4'h4) |=>
		loop2_ref_choice == 3'h4 && loop2_ref_choice_valid)
	else $error("reference four not selected");

	a_manual_hold:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[1:0] == 2'h3) |=>
		loop2_switchover_mode == SW_MAN_HOLDOVER && !loop2_auto_select && !loop2_revertive)
	else $error("manual holdover mode not decoded");

	a_manual_fallback:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[1:0] == 2'h2) |=>
		loop2_switchover_mode == SW_MAN_FALLBACK && !loop2_auto_select && !loop2_revertive)
	else $error("manual fallback mode not decoded");

	a_auto_nonrev:
	assert property ((wr_en && addr == `OFF_LOOP2_REF_SEL && wr_data[1:0] == 2'h0) |=>
		loop2_switchover_mode == SW_AUTO_NONREV && loop2_auto_select && !loop2_revertive)
	else $error("non-revertive mode not decoded");

	a_mantissa_low:
	assert property ((wr_en && addr == `OFF_TMR_MANT_LO) |=>
		loop1_switch_timer_mantissa[7:0] == $past(wr_data))
	else $error("mantissa low bits not updated");

	a_divider_high:
	assert property ((wr_en && addr == `OFF_IN0_DIV_HI) |=>
		loop1_in0_divider[15:8] == $past(wr_data))
	else $error("divider high byte not updated");

	a_divider_low:
	assert property ((wr_en && addr == `OFF_IN3_DIV_LO) |=>
		loop1_in3_divider[7:0] == $past(wr_data))
	else $error("divider low byte not updated");

	a_pd_disable:
	assert property ((wr_en && addr == `OFF_PD_SOURCE && wr_data[3:2] == 2'h0) |=>
		loop1_phase_detector_source == PD_OFF && !loop1_phase_detector_enable)
	else $error("detector source not disabled");

	a_pd_oscillator:
	assert property ((wr_en && addr == `OFF_PD_SOURCE && wr_data[3:2] == 2'h1) |=>
		loop1_phase_detector_source == PD_OSC && loop1_phase_detector_enable)
	else $error("oscillator source not selected");

	a_history_entry:
	assert property (($rose(loop1_in_holdover) && loop1_history_valid) |=>
		!loop1_free_run_active && !loop1_hold_last_active)
	else $error("history holdover shown as no history");

	a_holdover_exit:
	assert property ($fell(loop1_in_holdover) |=>
		!loop1_free_run_active && !loop1_hold_last_active)
	else $error("holdover state kept after exit");

endmodule : dpll_ref_switchover_config

// *** hw/loopcfg_defs.svh ***
// register offsets, field positions, reset values and widths
// assumes inclusion by the package and the design modules
`ifndef LOOPCFG_DEFS_SVH
`define LOOPCFG_DEFS_SVH

`define BASE_ADDR            9'h12C
`define NUM_REGS             21
`define ADDR_W               9
`define TIMER_W              42

`define OFF_LOOP2_VALIDATION 9'h12C
`define OFF_LOOP2_REF_SEL    9'h12D
`define OFF_LOOP1_POLICY     9'h12E
`define OFF_TMR_EXP          9'h12F
`define OFF_TMR_MANT_HI      9'h130
`define OFF_TMR_MANT_LO      9'h131
`define OFF_IN0_DIV_HI       9'h132
`define OFF_IN0_DIV_LO       9'h133
`define OFF_IN1_DIV_HI       9'h134
`define OFF_IN1_DIV_LO       9'h135
`define OFF_IN2_DIV_HI       9'h136
`define OFF_IN2_DIV_LO       9'h137
`define OFF_IN3_DIV_HI       9'h138
`define OFF_IN3_DIV_LO       9'h139
`define OFF_SPARE_A          9'h13A
`define OFF_SPARE_B          9'h13B
`define OFF_IN5_DIV_HI       9'h13C
`define OFF_IN5_DIV_LO       9'h13D
`define OFF_PD_SOURCE        9'h13E
`define OFF_SPARE_C          9'h13F
`define OFF_SPARE_D          9'h140

`define LOOPBACK_BIT         0
`define MAN_SRC_BIT          5
`define SOFT_REF_HI          4
`define SOFT_REF_LO          2
`define MODE_HI              1
`define MODE_LO              0
`define ALWAYS_SW_BIT        5
`define ALWAYS_FAST_BIT      4
`define HOLDOVER_MODE_BIT    2
`define TOPO_HI              1
`define TOPO_LO              0
`define EXP_HI               4
`define MANT_HI_BITS         2
`define PD_HI                3
`define PD_LO                2
`define MAX_SOFT_REF         3'h4

`define REG_RESET            8'h00

`endif

// *** hw/loopcfg_pkg.sv ***
// types shared by the switchover configuration block
// assumes the defs header is on the include path
package loopcfg_pkg;
	`include "loopcfg_defs.svh"

	typedef enum logic [1:0] {
		SW_AUTO_NONREV  = 2'b00,
		SW_AUTO_REV     = 2'b01,
		SW_MAN_FALLBACK = 2'b10,
		SW_MAN_HOLDOVER = 2'b11
	} switch_mode_e;

	typedef enum logic [1:0] {
		TOPO_SINGLE     = 2'b00,
		TOPO_REF_LOCKED = 2'b01,
		TOPO_OSC_LOCKED = 2'b10,
		TOPO_THREE_LOOP = 2'b11
	} topology_e;

	typedef enum logic [1:0] {
		PD_OFF      = 2'b00,
		PD_OSC      = 2'b01,
		PD_UNUSED   = 2'b10,
		PD_FEEDBACK = 2'b11
	} pd_source_e;

	typedef enum logic [1:0] {
		HO_LOCKED    = 2'b00,
		HO_HISTORY   = 2'b01,
		HO_FREE_RUN  = 2'b10,
		HO_HOLD_LAST = 2'b11
	} holdover_state_e;

	typedef struct packed {
		logic [`NUM_REGS-1:0][7:0] image;
		logic [1:0]                pin_meta;
		logic [1:0]                pin_sync;
		logic [7:0]                rdata;
	} cfg_state_s;

	typedef struct packed {
		holdover_state_e      ho;
		logic [`TIMER_W-1:0]  hold_time;
		logic                 fast;
		logic                 hitless;
	} policy_state_s;
endpackage : loopcfg_pkg

// *** hw/switch_policy.sv ***
// first loop switchover policy and holdover entry behaviour
// assumes holdover status inputs come from logic on sys_clk
`timescale 1ns/1ps
`include "loopcfg_defs.svh"
module switch_policy
	import loopcfg_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                always_switchover,
	input  wire logic                always_fast_lock,
	input  wire logic                holdover_mode,
	input  wire logic [4:0]          timer_exponent,
	input  wire logic [10:0]         timer_mantissa,
	input  wire logic                in_holdover,
	input  wire logic                history_valid,
	output logic                     use_fast_lock,
	output logic                     use_hitless,
	output holdover_state_e          holdover_state
);
	policy_state_s       cur;
	policy_state_s       next_cur;
	logic [`TIMER_W-1:0] threshold;
	logic                expired;

	always_comb begin
		threshold = `TIMER_W'(timer_mantissa) << timer_exponent;
		expired   = cur.hold_time >= threshold;
		next_cur  = cur;
		if (!in_holdover) begin
			next_cur.hold_time = '0;
		end else if (cur.hold_time != {`TIMER_W{1'b1}}) begin
			next_cur.hold_time = cur.hold_time + `TIMER_W'(1);
		end
		// fast lock bit wins at all times
		next_cur.fast    = always_fast_lock | (!always_switchover & expired);
		next_cur.hitless = !next_cur.fast;
		unique case (cur.ho)
			HO_LOCKED: begin
				if (in_holdover) begin
					if (history_valid) begin
						next_cur.ho = HO_HISTORY;
					end else if (holdover_mode) begin
						next_cur.ho = HO_HOLD_LAST;
					end else begin
						next_cur.ho = HO_FREE_RUN;
					end
				end
			end
			HO_HISTORY, HO_FREE_RUN, HO_HOLD_LAST: begin
				if (!in_holdover) begin
					next_cur.ho = HO_LOCKED;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur <= '{ho: HO_LOCKED, hold_time: '0, fast: 1'b0, hitless: 1'b1};
		end else begin
			cur <= next_cur;
		end
	end

	assign use_fast_lock  = cur.fast;
	assign use_hitless    = cur.hitless;
	assign holdover_state = cur.ho;
endmodule : switch_policy

// *** tb/dpll_ref_switchover_config_test.sv ***
// self-checking bench for the switchover configuration block
// assumes loopcfg_pkg and its defs header are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (b)); end end

module dpll_ref_switchover_config_test
	import loopcfg_pkg::*;
;
	logic                 sys_clk;
	logic                 rst;
	logic [`ADDR_W-1:0]   addr;
	logic [7:0]           wr_data;
	logic                 wr_en;
	logic                 rd_en;
	logic [7:0]           rd_data;
	logic [1:0]           loop2_select_pins;
	logic                 in_ho;
	logic                 hist_ok;
	logic [2:0]           choice;
	logic                 choice_ok;
	switch_mode_e         mode;
	logic                 auto_sel;
	logic                 revert;
	topology_e            topo;
	logic [4:0]           t_exp;
	logic [10:0]          t_mant;
	logic [15:0]          divs [5];
	pd_source_e           pd_src;
	logic                 pd_en;
	logic                 loopback;
	logic                 fast;
	logic                 hitless;
	logic                 free_run;
	logic                 hold_last;
	int                   fails = 0;
	int                   num_checks = 0;
	logic [7:0]           masks [`NUM_REGS] = '{8'h01, 8'h3F, 8'hFF, 8'h1F, 8'h07,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'h1F, 8'h9F, 8'h01};

	dpll_ref_switchover_config dut (
		.sys_clk                          (sys_clk),
		.rst                              (rst),
		.addr                             (addr),
		.wr_data                          (wr_data),
		.wr_en                            (wr_en),
		.rd_en                            (rd_en),
		.rd_data                          (rd_data),
		.loop2_select_pins                (loop2_select_pins),
		.loop1_in_holdover                (in_ho),
		.loop1_history_valid              (hist_ok),
		.loop2_ref_choice                 (choice),
		.loop2_ref_choice_valid           (choice_ok),
		.loop2_switchover_mode            (mode),
		.loop2_auto_select                (auto_sel),
		.loop2_revertive                  (revert),
		.loop1_topology                   (topo),
		.loop1_switch_timer_exponent      (t_exp),
		.loop1_switch_timer_mantissa      (t_mant),
		.loop1_in0_divider                (divs[0]),
		.loop1_in1_divider                (divs[1]),
		.loop1_in2_divider                (divs[2]),
		.loop1_in3_divider                (divs[3]),
		.loop1_in5_divider                (divs[4]),
		.loop1_phase_detector_source      (pd_src),
		.loop1_phase_detector_enable      (pd_en),
		.loop2_oscillator_loopback_enable (loopback),
		.loop1_use_fast_lock              (fast),
		.loop1_use_hitless                (hitless),
		.loop1_free_run_active            (free_run),
		.loop1_hold_last_active           (hold_last)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask : rd

	// write then read the same place with no gap
	task automatic wr_rd(input logic [`ADDR_W-1:0] a, input logic [7:0] d,
		output logic [7:0] v);
		@(posedge sys_clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		v = rd_data;
	endtask : wr_rd

	// high byte then low byte, back to back
	task automatic wr_pair(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr    <= a;
		wr_data <= d[15:8];
		wr_en   <= 1'b1;
		@(posedge sys_clk);
		addr    <= a + 9'h001;
		wr_data <= d[7:0];
		@(posedge sys_clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr_pair

	task automatic ho(input logic h, input logic v);
		@(posedge sys_clk);
		in_ho <= h;
		hist_ok <= v;
		cyc(3);
	endtask : ho

	// reset values, writable masks, unmapped places
	task automatic check_regs();
		logic [7:0] v;
		logic [`ADDR_W-1:0] a;
		for (int i = 0; i < `NUM_REGS; i++) begin
			a = `ADDR_W'(`BASE_ADDR + i);
			rd(a, v);
			`CHK(v, `REG_RESET)
			wr_rd(a, 8'hFF, v);
			`CHK(v, masks[i])
			wr(a, 8'h00);
		end
		wr_rd(9'h12B, 8'hFF, v);
		`CHK(v, 8'h00)
		wr_rd(9'h141, 8'hFF, v);
		`CHK(v, 8'h00)
		cyc(1);
		`CHK(rd_data, 8'h00)
	endtask : check_regs

	// soft codes, modes and pin selection of the second loop
	task automatic check_loop2();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(`OFF_LOOP2_REF_SEL, {3'h0, c, c[1:0]});
			`CHK(choice, c)
			`CHK(choice_ok, c <= `MAX_SOFT_REF)
			`CHK(mode, switch_mode_e'(c[1:0]))
			`CHK(auto_sel, ~c[1])
			`CHK(revert, c[1:0] == 2'h1)
		end
		wr(`OFF_LOOP2_REF_SEL, 8'h20);
		for (int p = 0; p < 4; p++) begin
			@(posedge sys_clk);
			loop2_select_pins <= 2'(p);
			cyc(3);
			`CHK(choice, {1'b0, 2'(p)})
			`CHK(choice_ok, 1'b1)
		end
		wr(`OFF_LOOP2_REF_SEL, 8'h0C);
		`CHK(choice, 3'h3)
	endtask : check_loop2

	// topology, detector source, loopback, timer and dividers
	task automatic check_fields();
		logic [`ADDR_W-1:0] a;
		for (int t = 0; t < 4; t++) begin
			wr(`OFF_LOOP1_POLICY, {6'h00, 2'(t)});
			`CHK(topo, topology_e'(t))
			wr(`OFF_PD_SOURCE, {4'h0, 2'(t), 2'h0});
			`CHK(pd_src, pd_source_e'(t))
			`CHK(pd_en, 1'(t))
		end
		wr(`OFF_LOOP2_VALIDATION, 8'h01);
		`CHK(loopback, 1'b1)
		wr(`OFF_LOOP2_VALIDATION, 8'hFE);
		`CHK(loopback, 1'b0)
		wr(`OFF_TMR_EXP, 8'hF3);
		`CHK(t_exp, 5'h13)
		wr(`OFF_TMR_MANT_HI, 8'hFD);
		wr(`OFF_TMR_MANT_LO, 8'hA7);
		`CHK(t_mant, 11'h5A7)
		for (int i = 0; i < 5; i++) begin
			a = (i < 4) ? `ADDR_W'(`OFF_IN0_DIV_HI + 2 * i) : `OFF_IN5_DIV_HI;
			wr_pair(a, {8'h90 + 8'(i), 8'h3C + 8'(i)});
			`CHK(divs[i], {8'h90 + 8'(i), 8'h3C + 8'(i)})
		end
	endtask : check_fields

	// switchover policy against holdover time and entry behaviour
	task automatic check_policy();
		wr(`OFF_TMR_EXP, 8'h01);
		wr(`OFF_TMR_MANT_HI, 8'h00);
		wr(`OFF_TMR_MANT_LO, 8'h04);
		wr(`OFF_LOOP1_POLICY, 8'h00);
		cyc(3);
		`CHK(hitless, 1'b1)
		ho(1'b1, 1'b0);
		`CHK(hitless, 1'b1)
		`CHK(free_run, 1'b1)
		`CHK(hold_last, 1'b0)
		cyc(8);
		`CHK(fast, 1'b1)
		`CHK(hitless, 1'b0)
		wr(`OFF_LOOP1_POLICY, 8'h20);
		cyc(3);
		`CHK(hitless, 1'b1)
		`CHK(fast, 1'b0)
		wr(`OFF_LOOP1_POLICY, 8'h10);
		cyc(3);
		`CHK(fast, 1'b1)
		ho(1'b0, 1'b0);
		`CHK(fast, 1'b1)
		wr(`OFF_LOOP1_POLICY, 8'h30);
		cyc(3);
		`CHK(fast, 1'b1)
		`CHK(hitless, 1'b0)
		wr(`OFF_LOOP1_POLICY, 8'h24);
		ho(1'b1, 1'b0);
		`CHK(hold_last, 1'b1)
		`CHK(free_run, 1'b0)
		`CHK(hitless, 1'b1)
		ho(1'b0, 1'b0);
		ho(1'b1, 1'b1);
		`CHK(hold_last, 1'b0)
		`CHK(free_run, 1'b0)
		ho(1'b0, 1'b0);
	endtask : check_policy

	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done

	initial begin
		rst = 1'b1;
		addr = '0;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		loop2_select_pins = 2'h0;
		in_ho = 1'b0;
		hist_ok = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		`CHK(choice, 3'h0)
		`CHK(choice_ok, 1'b1)
		check_regs();
		check_loop2();
		check_fields();
		check_policy();
		test_done();
	end
endmodule : dpll_ref_switchover_config_test
